// ===== hdl/pfm_counter.sv
`timescale 1ns/1ps
module pfm_counter import pfm_pkg::*; #(
   parameter int CNT_W = 18,
   parameter int DIV_W = 15,
   parameter int LF_W = 7
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic measured_input_pin_i,
   input wire logic secondary_gate_input_pin_i,
   input wire logic companion_timer_output_i,
   input wire logic lf_tick_i,
   input wire logic slow_mode_i,
   output logic [31:0] rdata_o,
   output logic timer_interrupt_o,
   output logic shared_port_pin_o,
   output logic shared_port_pin_en_o
);
   // ======================================
   // register file
   logic [6:0] ctrl1_q, ctrl1_d;
   logic [6:0] ctrl2_q, ctrl2_d;
   logic [7:0] gate_q, gate_d;
   logic [31:0] rdata_d;
   logic clr;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic ovf_q, ovf_d;
   logic gact;

   logic [1:0] start_f, mode_f, gsrc, gclk;
   logic [2:0] ssel;
   logic edge_sel, girq_both, route_blk, run;
   assign start_f = ctrl1_q[START_LSB +: 2];
   assign mode_f = ctrl1_q[MODE_LSB +: 2];
   assign ssel = ctrl1_q[SRC_LSB +: 3];
   assign edge_sel = ctrl2_q[EDGE_BIT];
   assign gsrc = ctrl2_q[GSRC_LSB +: 2];
   assign girq_both = ctrl2_q[GIRQ_BIT];
   assign gclk = ctrl2_q[GCLK_LSB +: 2];
   assign route_blk = ctrl2_q[ROUTE_BIT];
   assign run = (start_f != START_STOP);

   always_comb begin
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      gate_d = gate_q;
      clr = 1'b0;
      rdata_d = 32'h0000_0000;
      if (wr_i) begin
         unique case (addr_i)
            OFS_CTRL1: begin
               // clear is a strobe, not stored
               ctrl1_d = wdata_i[6:0];
               clr = wdata_i[CLR_BIT];
            end
            OFS_CTRL2: ctrl2_d = wdata_i[6:0];
            OFS_GATE: gate_d = wdata_i[7:0];
            default: ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            OFS_CTRL1: rdata_d = {25'h0, ctrl1_q};
            OFS_CTRL2: rdata_d = {25'h0, ctrl2_q};
            OFS_GATE: rdata_d = {24'h0, gate_q};
            OFS_CAP: rdata_d = 32'(cnt_q);
            OFS_STAT: rdata_d = {30'h0, gact, ovf_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl1_q <= CTRL1_RST;
         ctrl2_q <= CTRL2_RST;
         gate_q <= GATE_RST;
         rdata_o <= 32'h0000_0000;
      end else begin
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         gate_q <= gate_d;
         rdata_o <= rdata_d;
      end
   end

   // ======================================
   // prescaler and gate tick
   logic [DIV_W-1:0] div_q, div_d, fmask;
   logic [LF_W-1:0] lf_q, lf_d, smask;
   logic gtick, src_lvl;

   always_comb begin
      div_d = div_q + DIV_W'(1);
      lf_d = lf_tick_i ? lf_q + LF_W'(1) : lf_q;
      fmask = ~({DIV_W{1'b1}} << (GFAST_BASE + int'(gclk)));
      smask = ~({LF_W{1'b1}} << (GSLOW_BASE + int'(gclk)));
      // ticks come off the free divider, so a start waits for the next one
      if (slow_mode_i) begin
         gtick = lf_tick_i && ((lf_q & smask) == smask);
      end else begin
         gtick = ((div_q & fmask) == fmask);
      end
      src_lvl = div_q[ssel];
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q <= '0;
         lf_q <= '0;
      end else begin
         div_q <= div_d;
         lf_q <= lf_d;
      end
   end

   // ======================================
   // internal window gate
   pfm_gate_type gst_q, gst_d;
   logic [3:0] per_q, per_d;
   logic gen_en;
   assign gen_en = run && (mode_f == MODE_FM) && (gsrc == GSRC_INT);

   always_comb begin
      gst_d = gst_q;
      per_d = per_q;
      if (!gen_en) begin
         gst_d = G_IDLE;
      end else if (gtick) begin
         unique case (gst_q)
            G_IDLE: begin
               gst_d = G_HIGH;
               per_d = gate_q[HIGH_LSB +: 4];
            end
            G_HIGH: begin
               if (per_q == PER_LAST) begin
                  // low length sampled only here: later writes wait a period
                  gst_d = G_LOW;
                  per_d = gate_q[LOW_LSB +: 4];
               end else begin
                  per_d = per_q + 4'h1;
               end
            end
            G_LOW: begin
               if (per_q == PER_LAST) begin
                  gst_d = G_HIGH;
                  per_d = gate_q[HIGH_LSB +: 4];
               end else begin
                  per_d = per_q + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gst_q <= G_IDLE;
         per_q <= 4'h0;
      end else begin
         gst_q <= gst_d;
         per_q <= per_d;
      end
   end

   // ======================================
   // measurement counter
   logic win, win_q, andp, andp_q, gate, gate_q2, andf, andf_q, meas_q;
   logic inc, irq_d, irq_q, pin_d, pin_q, pen_d, pen_q;
   logic pw_fall, fm_inc;

   always_comb begin
      unique case (gsrc)
         GSRC_PIN: gate = secondary_gate_input_pin_i;
         GSRC_INT: gate = (gst_q == G_HIGH);
         GSRC_COMP: gate = companion_timer_output_i;
         default: gate = 1'b0;
      endcase
      gate = gate && run && (mode_f == MODE_FM);
      win = measured_input_pin_i && run && (mode_f == MODE_PW);
      andp = win && src_lvl;
      andf = measured_input_pin_i && gate;
      pw_fall = andp_q && !andp;
      if (edge_sel) begin
         fm_inc = (gate && (measured_input_pin_i != meas_q)) || (gate_q2 && !gate);
      end else begin
         fm_inc = andf_q && !andf;
      end
      inc = (mode_f == MODE_PW) ? pw_fall : ((mode_f == MODE_FM) && fm_inc);
      // a stop while high is a window fall too, hence the stop interrupt
      irq_d = 1'b0;
      if (mode_f == MODE_PW) begin
         irq_d = (win_q && !win) || (girq_both && win && !win_q);
      end else if (mode_f == MODE_FM) begin
         irq_d = (gate_q2 && !gate) || (girq_both && gate && !gate_q2);
      end
      gact = (mode_f == MODE_FM) && gate;
      cnt_d = cnt_q;
      ovf_d = ovf_q && !clr;
      if (clr) begin
         cnt_d = '0;
      end else if (inc) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
      if (inc && (&cnt_q)) begin
         ovf_d = 1'b1;
      end
      pin_d = companion_timer_output_i && !route_blk;
      pen_d = !route_blk;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         win_q <= 1'b0;
         andp_q <= 1'b0;
         gate_q2 <= 1'b0;
         andf_q <= 1'b0;
         meas_q <= 1'b0;
         cnt_q <= '0;
         ovf_q <= 1'b0;
         irq_q <= 1'b0;
         pin_q <= 1'b0;
         pen_q <= 1'b0;
      end else begin
         win_q <= win;
         andp_q <= andp;
         gate_q2 <= gate;
         andf_q <= andf;
         meas_q <= measured_input_pin_i;
         cnt_q <= cnt_d;
         ovf_q <= ovf_d;
         irq_q <= irq_d;
         pin_q <= pin_d;
         pen_q <= pen_d;
      end
   end

   assign timer_interrupt_o = irq_q;
   assign shared_port_pin_o = pin_q;
   assign shared_port_pin_en_o = pen_q;

   // ======================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   ovf_set_a: assert property (inc && (&cnt_q) && !clr |=> ovf_q && cnt_q == '0)
      else $error("wrap did not set overflow");
   ovf_hold_a: assert property (ovf_q && !clr |=> ovf_q)
      else $error("overflow lost without clear");
   cnt_resume_a: assert property (!inc && !clr |=> $stable(cnt_q))
      else $error("counter moved without cause");
   pw_count_a: assert property ((mode_f == MODE_PW) && pw_fall && !clr
      |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("pulse width count missed");
   pw_irq_a: assert property ((mode_f == MODE_PW) && win_q && !win
      |=> timer_interrupt_o)
      else $error("no interrupt on window fall");
   pw_start_irq_a: assert property ((mode_f == MODE_PW) && girq_both && win && !win_q
      |=> timer_interrupt_o)
      else $error("no interrupt on start with input high");
   fm_gate_fall_a: assert property (edge_sel && (mode_f == MODE_FM) && gate_q2 && !gate && !clr
      |=> cnt_q != $past(cnt_q) && timer_interrupt_o)
      else $error("gate fall did not count");
   gate_swap_a: assert property ((gst_q == G_HIGH) && gen_en && gtick && per_q == PER_LAST
      |=> gst_q == G_LOW && per_q == $past(gate_q[LOW_LSB +: 4]))
      else $error("gate low phase not entered");
   gate_mon_a: assert property (rd_i && addr_i == OFS_STAT && (mode_f == MODE_PW)
      |=> !rdata_o[GACT_BIT])
      else $error("activity monitor set in pulse width mode");
   route_a: assert property (route_blk |=> !shared_port_pin_en_o ##0 !shared_port_pin_o)
      else $error("blocked companion output reached pin");

   // ======================================
   // register port checks
   wr_ctrl1_a: assert property (wr_i && addr_i == OFS_CTRL1
      |=> ctrl1_q == $past(wdata_i[6:0]))
      else $error("control one write lost bits");

   wr_ctrl2_a: assert property (wr_i && addr_i == OFS_CTRL2
      |=> ctrl2_q == $past(wdata_i[6:0]))
      else $error("control two write lost bits");

   clr_strobe_a: assert property (wr_i && addr_i == OFS_CTRL1 && wdata_i[CLR_BIT]
      |-> clr)
      else $error("clear strobe not decoded");

   cap_read_a: assert property (rd_i && addr_i == OFS_CAP
      |=> rdata_o == 32'($past(cnt_q)))
      else $error("capture read returned wrong value");

   stat_ovf_a: assert property (rd_i && addr_i == OFS_STAT
      |=> rdata_o[OVF_BIT] == $past(ovf_q))
      else $error("overflow monitor read wrong");

   stat_upper_a: assert property (rd_i && addr_i == OFS_STAT
      |=> rdata_o[31:2] == 30'h0)
      else $error("status upper bits not zero");

   // ======================================
   // counter checks
   // clear wins over a count, but a wrap in the same cycle still flags
   clr_cnt_a: assert property (clr && !(inc && (&cnt_q))
      |=> !ovf_q && cnt_q == '0)
      else $error("clear did not reset counter and flag");

   idle_mode_a: assert property ((mode_f != MODE_PW) && (mode_f != MODE_FM) && !clr
      |=> $stable(cnt_q))
      else $error("counter moved in idle mode");

   pw_hold_a: assert property ((mode_f == MODE_PW) && !andp_q && !clr
      |=> $stable(cnt_q))
      else $error("pulse width count without falling edge");

   fm_gate_low_a: assert property ((mode_f == MODE_FM) && !gate && !gate_q2 && !clr
      |=> $stable(cnt_q))
      else $error("frequency count while gate low");

   fm_and_fall_a: assert property ((mode_f == MODE_FM) && !edge_sel && andf_q && !andf && !clr
      |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("and-ed falling edge not counted");

   // ======================================
   // interrupt checks
   fm_irq_a: assert property ((mode_f == MODE_FM) && gate_q2 && !gate
      |=> timer_interrupt_o)
      else $error("no interrupt on gate fall");

   fm_both_irq_a: assert property ((mode_f == MODE_FM) && girq_both && gate && !gate_q2
      |=> timer_interrupt_o)
      else $error("no interrupt on gate rise");

   irq_cause_a: assert property (!(win_q && !win) && !(win && !win_q) && !(gate_q2 && !gate) && !(gate && !gate_q2)
      |=> !timer_interrupt_o)
      else $error("interrupt without window edge");

   // ======================================
   // gate selection and monitor checks
   gact_off_a: assert property ((mode_f != MODE_FM)
      |-> !gact)
      else $error("activity monitor set outside frequency mode");

   gact_gate_a: assert property ((mode_f == MODE_FM)
      |-> gact == gate)
      else $error("activity monitor differs from gate");

   gsrc_pin_a: assert property ((mode_f == MODE_FM) && run && (gsrc == GSRC_PIN)
      |-> gate == secondary_gate_input_pin_i)
      else $error("pin gate not selected");

   gsrc_int_a: assert property ((mode_f == MODE_FM) && run && (gsrc == GSRC_INT)
      |-> gate == (gst_q == G_HIGH))
      else $error("internal gate not selected");

   gsrc_rsvd_a: assert property ((gsrc == 2'h3)
      |-> !gate)
      else $error("reserved gate source not low");

   pin_route_a: assert property (!route_blk
      |=> shared_port_pin_en_o && shared_port_pin_o == $past(companion_timer_output_i))
      else $error("routed companion output not on pin");

   // ======================================
   // internal gate generator checks
   gen_idle_a: assert property (!gen_en
      |=> gst_q == G_IDLE)
      else $error("gate generator not idle when disabled");

   gen_wait_a: assert property (gen_en && (gst_q == G_IDLE) && !gtick
      |=> gst_q == G_IDLE)
      else $error("gate started off a divider tick");

   gen_hold_a: assert property (gen_en && !gtick
      |=> $stable(gst_q) && $stable(per_q))
      else $error("gate moved without tick");

   gen_step_a: assert property (gen_en && gtick && (gst_q != G_IDLE) && per_q != PER_LAST
      |=> per_q == $past(per_q) + 4'h1 && $stable(gst_q))
      else $error("gate period count did not step");

   gate_rise_a: assert property ((gst_q == G_LOW) && gen_en && gtick && per_q == PER_LAST
      |=> gst_q == G_HIGH && per_q == $past(gate_q[HIGH_LSB +: 4]))
      else $error("gate high phase not entered");
endmodule

// ===== hdl/pfm_pkg.sv
// Overview of operation
// - pulse width: count falling edges of measured input ANDed with source clock
// - pulse width: interrupt on window fall, or both edges if selected
// - without clear, counting resumes from last held value
// - counter wrap from all ones to zero sets overflow flag
// - overflow flag holds until counter clear
// - stop while measured input high interrupts; interrupt is a one-clock pulse, no pending latch
// - start with both edges and input high interrupts at once
// - input fall while source clock high adds one count
// - frequency mode counts input edges only while window gate high
// - frequency mode interrupts on gate fall, or both gate edges
// - frequency mode shows gate state in activity monitor
// - companion route bit only gates companion output onto shared pin
// - gate high period is (16 - high setting) scaled gate ticks
// - gate low period is (16 - low setting) same scaled ticks
// - internal gate alternates high and low periods set independently
// - internal gate synchronised to divider, may start one tick late
// - low setting written during low period applies from next low period
// - edge select 1: each gate fall adds one count
// - edge select 0: count falls of input ANDed with gate
// - gate source 00 secondary pin, 01 internal, 10 companion, 11 reserved
// - activity monitor 1 in high period, 0 otherwise; overflow monitor
package pfm_pkg;
   // ======================================
   // register offsets
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_GATE = 8'h08;
   localparam logic [7:0] OFS_CAP = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   // ======================================
   // field positions
   localparam int START_LSB = 0;
   localparam int MODE_LSB = 2;
   localparam int SRC_LSB = 4;
   localparam int CLR_BIT = 7;
   localparam int EDGE_BIT = 0;
   localparam int GSRC_LSB = 1;
   localparam int GIRQ_BIT = 3;
   localparam int GCLK_LSB = 4;
   localparam int ROUTE_BIT = 6;
   localparam int HIGH_LSB = 0;
   localparam int LOW_LSB = 4;
   localparam int OVF_BIT = 0;
   localparam int GACT_BIT = 1;
   // ======================================
   // reset values and codes
   localparam logic [6:0] CTRL1_RST = 7'h00;
   localparam logic [6:0] CTRL2_RST = 7'h00;
   localparam logic [7:0] GATE_RST = 8'h00;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_RUN = 2'h2;
   localparam logic [1:0] MODE_PW = 2'h2;
   localparam logic [1:0] MODE_FM = 2'h3;
   localparam logic [1:0] GSRC_PIN = 2'h0;
   localparam logic [1:0] GSRC_INT = 2'h1;
   localparam logic [1:0] GSRC_COMP = 2'h2;
   localparam int GFAST_BASE = 12;
   localparam int GSLOW_BASE = 4;
   localparam logic [3:0] PER_LAST = 4'hF;
   typedef enum logic [2:0] {
      G_IDLE = 3'b001,
      G_HIGH = 3'b010,
      G_LOW = 3'b100
   } pfm_gate_type;
endpackage

// ===== bench/pfm_pulse_src.sv
`timescale 1ns/1ps
// ======================================
// external pulse source on the measured pin
module pfm_pulse_src #(
   parameter int HALF = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic go_i,
   input wire logic [7:0] num_i,
   input wire logic level_i,
   output logic pin_o,
   output logic busy_o
);
   logic [7:0] left_q;
   int ph_q;
   // pin only moves just after an edge, like a real synchronous source
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         left_q <= 8'h00;
         ph_q <= 0;
         pin_o <= 1'b0;
      end else if (go_i) begin
         left_q <= num_i;
         ph_q <= HALF;
         pin_o <= 1'b1;
      end else if (left_q != 8'h00) begin
         if (ph_q > 1) begin
            ph_q <= ph_q - 1;
         end else begin
            ph_q <= HALF;
            pin_o <= ~pin_o;
            if (pin_o) begin
               left_q <= left_q - 8'h01;
            end
         end
      end else begin
         pin_o <= level_i;
      end
   end
   assign busy_o = (left_q != 8'h00);
endmodule

// ===== bench/test_pulse_width_freq_measure_counter.sv
`timescale 1ns/1ps
module test_pulse_width_freq_measure_counter;
   import pfm_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gate = 1'b0;
   logic comp = 1'b0;
   logic lf = 1'b0;
   logic slow = 1'b0;
   logic go = 1'b0;
   logic lvl = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic irq, pin, pin_en, meas, busy;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int irqs = 0;
   int last_irq = 0;
   int k, t;
   pfm_counter pfm_counter_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .measured_input_pin_i(meas), .secondary_gate_input_pin_i(gate),
      .companion_timer_output_i(comp), .lf_tick_i(lf), .slow_mode_i(slow), .rdata_o(rdata),
      .timer_interrupt_o(irq), .shared_port_pin_o(pin), .shared_port_pin_en_o(pin_en));
   pfm_pulse_src pfm_pulse_src_i (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .num_i(8'h05),
      .level_i(lvl), .pin_o(meas), .busy_o(busy));
   // ======================================
   // clock, slow ticks, interrupt log, timeout
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      lf <= (cyc % 4 == 3);
      if (irq === 1'b1) begin
         irqs <= irqs + 1;
         last_irq <= cyc;
      end
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   // ======================================
   // bus and compare helpers
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 rv = rdata;
      // hand back on an edge so the caller drives right after it
      @(posedge clk_i);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
      samples_checked++;
      if ((^g === 1'bx) || (g < lo) || (g > hi)) begin
         miscompares++;
         $display("BAD %0t got %0d outside %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic wirq(input int lim);
      int k0, n;
      k0 = irqs;
      n = 0;
      while (irqs == k0 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk(irqs != k0, 1);
   endtask
   task automatic gate_pulse(input int n);
      @(posedge clk_i) gate <= 1'b1;
      cycles(n);
      gate <= 1'b0;
      cycles(4);
   endtask
   // ======================================
   // scenarios
   task automatic t_regs;
      rd_reg(OFS_CTRL1); chk(rv, 32'h0);
      rd_reg(OFS_STAT); chk(rv, 32'h0);
      rd_reg(8'h20); chk(rv, 32'h0);
      wr_reg(OFS_GATE, 32'h5A);
      rd_reg(OFS_GATE); chk(rv, 32'h5A);
      rd_reg(OFS_CAP); chk(rv, 32'h0);
   endtask
   task automatic t_freq;
      wr_reg(OFS_CTRL2, 32'h00);
      wr_reg(OFS_CTRL1, 32'h8E);
      @(posedge clk_i) gate <= 1'b1;
      cycles(4);
      rd_reg(OFS_STAT); chk(rv, 32'h2);
      go <= 1'b1;
      @(posedge clk_i) go <= 1'b0;
      cycles(30);
      k = irqs;
      gate <= 1'b0;
      cycles(4);
      chk(irqs - k, 1);
      rd_reg(OFS_CAP); chk(rv, 32'h5);
      rd_reg(OFS_STAT); chk(rv, 32'h0);
      gate_pulse(6);
      rd_reg(OFS_CAP); chk(rv, 32'h5);
      wr_reg(OFS_CTRL1, 32'h8E);
      rd_reg(OFS_CAP); chk(rv, 32'h0);
   endtask
   task automatic t_edge1;
      wr_reg(OFS_CTRL1, 32'h00);
      lvl <= 1'b1;
      wr_reg(OFS_CTRL2, 32'h09);
      wr_reg(OFS_CTRL1, 32'h8E);
      k = irqs;
      gate_pulse(10);
      rd_reg(OFS_CAP); chk(rv, 32'h1);
      chk(irqs - k, 2);
      lvl <= 1'b0;
      wr_reg(OFS_CTRL1, 32'h00);
   endtask
   task automatic t_pw;
      wr_reg(OFS_CTRL2, 32'h00);
      wr_reg(OFS_CTRL1, 32'h8A);
      k = irqs;
      lvl <= 1'b1;
      cycles(40);
      lvl <= 1'b0;
      cycles(4);
      rd_reg(OFS_CAP); chk_rng(rv, 19, 21);
      chk(irqs - k, 1);
      lvl <= 1'b1;
      cycles(40);
      lvl <= 1'b0;
      cycles(4);
      rd_reg(OFS_CAP); chk_rng(rv, 38, 42);
      wr_reg(OFS_CTRL1, 32'h08);
      wr_reg(OFS_CTRL2, 32'h08);
      lvl <= 1'b1;
      cycles(3);
      k = irqs;
      wr_reg(OFS_CTRL1, 32'h0A);
      cycles(3);
      chk(irqs - k, 1);
      k = irqs;
      wr_reg(OFS_CTRL1, 32'h08);
      cycles(3);
      chk(irqs - k, 1);
      lvl <= 1'b0;
   endtask
   task automatic t_gate;
      slow <= 1'b1;
      wr_reg(OFS_GATE, 32'hDE);
      wr_reg(OFS_CTRL2, 32'h0A);
      wr_reg(OFS_CTRL1, 32'h8E);
      wirq(200);
      t = last_irq;
      wirq(300);
      chk_rng(last_irq - t, 127, 129);
      t = last_irq;
      wirq(300);
      chk_rng(last_irq - t, 191, 193);
      wr_reg(OFS_CTRL1, 32'h00);
      slow <= 1'b0;
   endtask
   task automatic t_route;
      wr_reg(OFS_CTRL2, 32'h04);
      wr_reg(OFS_CTRL1, 32'h0E);
      comp <= 1'b1;
      cycles(3);
      chk({pin_en, pin}, 2'b11);
      rd_reg(OFS_STAT); chk(rv, 32'h2);
      wr_reg(OFS_CTRL2, 32'h44);
      cycles(2);
      chk({pin_en, pin}, 2'b00);
      rd_reg(OFS_STAT); chk(rv, 32'h2);
      wr_reg(OFS_CTRL2, 32'h06);
      rd_reg(OFS_STAT); chk(rv, 32'h0);
      comp <= 1'b0;
      wr_reg(OFS_CTRL1, 32'h00);
   endtask
   task automatic conclude;
      $display("mismatches %0d of %0d checks", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      cycles(2);
      nrst_i <= 1'b1;
      t_regs();
      t_freq();
      t_edge1();
      t_pw();
      t_gate();
      t_route();
      conclude();
   end
endmodule
